// [adcr_pkg.sv]
// Shared constants, types and helpers for the converter link
package adcr_pkg;

  // Data widths and filter depth
  localparam int ADCR_MOD_W      = 18;
  localparam int ADCR_WORD_W     = 16;
  localparam int ADCR_NUM_STAGES = 3;
  localparam int ADCR_FLUSH_W    = 9;

  // Full scale of the output word, in modulator units
  localparam logic signed [ADCR_MOD_W-1:0] ADCR_FS_POS  = 18'h07fff;
  localparam logic signed [ADCR_MOD_W-1:0] ADCR_FS_NEG  = 18'h38000;
  // Modulator clip level, 3% past full scale
  localparam logic signed [ADCR_MOD_W-1:0] ADCR_MOD_POS = 18'h083d6;
  localparam logic signed [ADCR_MOD_W-1:0] ADCR_MOD_NEG = 18'h37c2a;

  // Timing: core clock rate and documented delays
  localparam int ADCR_CLK_MHZ       = 200;
  localparam int ADCR_DAV_DLY_NS    = 15;
  localparam int ADCR_DAV_DLY_CYC   =
    (ADCR_DAV_DLY_NS * ADCR_CLK_MHZ + 999) / 1000;
  // Modulator flag delay is 3.5 periods, held as half periods
  localparam int ADCR_MOD_OTR_HALF  = 7;
  localparam int ADCR_MOD_OTR_CYC   = (ADCR_MOD_OTR_HALF + 1) / 2;
  // Least reset hold: one sample period
  localparam int ADCR_RST_HOLD_CYC  = 1;

  // Flush lengths in samples per decimation mode
  localparam logic [ADCR_FLUSH_W-1:0] ADCR_FLUSH_8X = 9'h141;
  localparam logic [ADCR_FLUSH_W-1:0] ADCR_FLUSH_4X = 9'h06c;
  localparam logic [ADCR_FLUSH_W-1:0] ADCR_FLUSH_2X = 9'h017;
  localparam logic [ADCR_FLUSH_W-1:0] ADCR_FLUSH_1X = 9'h001;

  // Decimation modes
  typedef enum logic [3:0] {
    ADCR_DEC1 = 4'h1,
    ADCR_DEC2 = 4'h2,
    ADCR_DEC4 = 4'h4,
    ADCR_DEC8 = 4'h8
  } adcr_mode_type;

  // Divider mask: ratio minus one
  function automatic logic [2:0] decMask(input adcr_mode_type m);
    case (m)
      ADCR_DEC2: return 3'h1;
      ADCR_DEC4: return 3'h3;
      ADCR_DEC8: return 3'h7;
      default:   return 3'h0;
    endcase
  endfunction

  // Samples to discard after a reset pulse
  function automatic logic [ADCR_FLUSH_W-1:0] flushLen(
    input adcr_mode_type m);
    case (m)
      ADCR_DEC2: return ADCR_FLUSH_2X;
      ADCR_DEC4: return ADCR_FLUSH_4X;
      ADCR_DEC8: return ADCR_FLUSH_8X;
      default:   return ADCR_FLUSH_1X;
    endcase
  endfunction

endpackage

// [adcr_link_if.sv]
// Link between the converter end and the capture end
`timescale 1ns/1ps
interface adcr_link_if;
  import adcr_pkg::*;

  // Reset from capture end, active low
  logic                   resetN;
  // Converter outputs
  logic                   dataValidStrobe;
  logic [ADCR_WORD_W-1:0] outputWordBits;
  logic                   overrangeFlag;

  modport dev (
    input  resetN,
    output dataValidStrobe,
    output outputWordBits,
    output overrangeFlag
  );

  modport cap (
    output resetN,
    input  dataValidStrobe,
    input  outputWordBits,
    input  overrangeFlag
  );
endinterface

// [adcr_device.sv]
// Converter end: reset, divider, decimation, overrange and word output
`timescale 1ns/1ps
module adcr_device
  import adcr_pkg::*;
(
  // Clock, reset and freeze
  input  wire logic                         core_clk,
  input  wire logic                         rst,
  input  wire logic                         ce,
  // Modulator data, same clock domain
  input  wire logic signed [ADCR_MOD_W-1:0] modSample,
  // Mode comparators, thermometer coded, asynchronous
  input  wire logic [2:0]                   modeCmp,
  // Link to capture end
  adcr_link_if.dev                          link
);

  localparam int NSTG = ADCR_NUM_STAGES;
  localparam int DDLY = ADCR_DAV_DLY_CYC;
  localparam int ODLY = ADCR_MOD_OTR_CYC;

  typedef logic signed [ADCR_MOD_W-1:0] adcr_smp_type;

  // Limit a value to the output word range
  function automatic adcr_smp_type satFs(input adcr_smp_type v);
    if (v > ADCR_FS_POS)
      return ADCR_FS_POS;
    else if (v < ADCR_FS_NEG)
      return ADCR_FS_NEG;
    else
      return v;
  endfunction

  // True when a value lies past full scale
  function automatic logic pastFs(input adcr_smp_type v);
    return (v > ADCR_FS_POS) || (v < ADCR_FS_NEG);
  endfunction

  // Link reset read directly, so no clock edge is needed to act
  logic running;
  assign running = link.resetN;

  // Mode comparator synchroniser and encoder
  logic [2:0]    cmpMeta_q;
  logic [2:0]    cmpMeta_d;
  logic [2:0]    cmpSync_q;
  logic [2:0]    cmpSync_d;
  adcr_mode_type mode_q;
  adcr_mode_type mode_d;

  // Highest comparator wins, so a torn code still picks a mode
  always_comb
  begin
    cmpMeta_d = modeCmp;
    cmpSync_d = cmpMeta_q;
    casez (cmpSync_q)
      3'b1??:  mode_d = ADCR_DEC1;
      3'b01?:  mode_d = ADCR_DEC4;
      3'b001:  mode_d = ADCR_DEC2;
      default: mode_d = ADCR_DEC8;
    endcase
  end

  // Latched every edge; a mode change mid-run corrupts one word
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cmpMeta_q <= 3'h0;
      cmpSync_q <= 3'h0;
      mode_q    <= ADCR_DEC8;
    end
    else if (ce)
    begin
      cmpMeta_q <= cmpMeta_d;
      cmpSync_q <= cmpSync_d;
      mode_q    <= mode_d;
    end
  end

  // Divider, strobe delay line and modulator front end
  logic [2:0]        divCnt_q;
  logic [2:0]        divCnt_d;
  logic [DDLY-1:0]   davPipe_q;
  logic [DDLY-1:0]   davPipe_d;
  logic [ODLY-1:0]   modFlag_q;
  logic [ODLY-1:0]   modFlag_d;
  adcr_smp_type      modReg_q;
  adcr_smp_type      modReg_d;
  logic [2:0]        mask;
  logic              davRaw;

  always_comb
  begin
    mask      = decMask(mode_q);
    // High in the first half of each ratio group, and on every cycle in 1x mode
    davRaw    = running && ((divCnt_q & (mask ^ (mask >> 1))) == 3'h0);
    davPipe_d = {davPipe_q[DDLY-2:0], davRaw};
    modFlag_d = {modFlag_q[ODLY-2:0],
                 modSample > ADCR_MOD_POS || modSample < ADCR_MOD_NEG};
    divCnt_d  = divCnt_q + 3'h1;
    if (modSample > ADCR_MOD_POS)
      modReg_d = ADCR_MOD_POS;
    else if (modSample < ADCR_MOD_NEG)
      modReg_d = ADCR_MOD_NEG;
    else
      modReg_d = modSample;
    if (!running)
    begin
      // Dividers and modulator stay cleared while reset is low
      divCnt_d  = 3'h0;
      davPipe_d = '0;
      modFlag_d = '0;
      modReg_d  = '0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      divCnt_q  <= 3'h0;
      davPipe_q <= '0;
      modFlag_q <= '0;
      modReg_q  <= '0;
    end
    else if (ce)
    begin
      divCnt_q  <= divCnt_d;
      davPipe_q <= davPipe_d;
      modFlag_q <= modFlag_d;
      modReg_q  <= modReg_d;
    end
  end

  // Three half-band stages, each a pair average with its own toggle
  adcr_smp_type    stgIn  [NSTG];
  adcr_smp_type    stgOut [NSTG];
  logic [NSTG-1:0] inVld;
  logic [NSTG-1:0] stgVld;
  logic [NSTG-1:0] stgLim;

  genvar k;
  generate
    for (k = 0; k < NSTG; k++)
    begin : g_stage
      adcr_smp_type        hold_q;
      adcr_smp_type        hold_d;
      adcr_smp_type        out_q;
      adcr_smp_type        out_d;
      adcr_smp_type        avg;
      logic [ADCR_MOD_W:0] sum;
      logic                tg_q;
      logic                tg_d;
      logic                vld_q;
      logic                vld_d;
      logic                lim_q;
      logic                lim_d;

      if (k == 0)
      begin : g_first
        assign stgIn[k] = modReg_q;
        assign inVld[k] = running;
      end
      else
      begin : g_next
        assign stgIn[k] = stgOut[k-1];
        assign inVld[k] = running && stgVld[k-1];
      end

      // Data registers ignore link reset; only the toggle and the valid pulse clear
      always_comb
      begin
        sum   = {hold_q[ADCR_MOD_W-1], hold_q}
              + {stgIn[k][ADCR_MOD_W-1], stgIn[k]};
        avg   = sum[ADCR_MOD_W:1];
        hold_d = hold_q;
        out_d  = out_q;
        lim_d  = lim_q;
        tg_d   = tg_q;
        vld_d  = 1'b0;
        if (inVld[k])
        begin
          tg_d = !tg_q;
          if (!tg_q)
            hold_d = stgIn[k];
          else
          begin
            vld_d = 1'b1;
            if (k == NSTG - 1)
            begin
              out_d = satFs(avg);
              lim_d = pastFs(avg);
            end
            else
              out_d = avg;
          end
        end
        if (!running)
          tg_d = 1'b0;
      end

      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          hold_q <= '0;
          out_q  <= '0;
          tg_q   <= 1'b0;
          vld_q  <= 1'b0;
          lim_q  <= 1'b0;
        end
        else if (ce)
        begin
          hold_q <= hold_d;
          out_q  <= out_d;
          tg_q   <= tg_d;
          vld_q  <= vld_d;
          lim_q  <= lim_d;
        end
      end

      assign stgOut[k] = out_q;
      assign stgVld[k] = vld_q;
      assign stgLim[k] = lim_q;
    end
  endgenerate

  // Output tap, word register and overrange flag
  logic [ADCR_WORD_W-1:0] pend_q;
  logic [ADCR_WORD_W-1:0] pend_d;
  logic [ADCR_WORD_W-1:0] word_q;
  logic [ADCR_WORD_W-1:0] word_d;
  logic                   davPrev_q;
  logic                   davPrev_d;
  logic                   otr_q;
  logic                   otr_d;
  logic                   davNow;
  adcr_smp_type           tap;
  logic                   tapVld;
  adcr_smp_type           tapSat;

  always_comb
  begin
    case (mode_q)
      ADCR_DEC2: tap = stgOut[0];
      ADCR_DEC4: tap = stgOut[1];
      ADCR_DEC8: tap = stgOut[2];
      default:   tap = modReg_q;
    endcase
    case (mode_q)
      ADCR_DEC2: tapVld = stgVld[0];
      ADCR_DEC4: tapVld = stgVld[1];
      ADCR_DEC8: tapVld = stgVld[2];
      default:   tapVld = running;
    endcase
    tapSat    = satFs(tap);
    davNow    = davPipe_q[DDLY-1] && running;
    davPrev_d = davNow;
    pend_d    = tapVld ? tapSat[ADCR_WORD_W-1:0] : pend_q;
    // Word moves the edge after the strobe rises, or every edge in 1x mode; frozen during reset
    word_d    = ((davNow && !davPrev_q) || (mode_q == ADCR_DEC1 && running))
              ? pend_q : word_q;
    otr_d     = modFlag_q[ODLY-1] || stgLim[NSTG-1];
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pend_q    <= '0;
      word_q    <= '0;
      davPrev_q <= 1'b0;
      otr_q     <= 1'b0;
    end
    else if (ce)
    begin
      pend_q    <= pend_d;
      word_q    <= word_d;
      davPrev_q <= davPrev_d;
      otr_q     <= otr_d;
    end
  end

  // Strobe gated by the live reset so it drops without an edge
  assign link.dataValidStrobe = davPipe_q[DDLY-1] && running;
  assign link.outputWordBits  = word_q;
  assign link.overrangeFlag   = otr_q;

endmodule

// [adcr_capture.sv]
// Capture end: drives the shared reset, flushes, and takes words
`timescale 1ns/1ps
module adcr_capture
  import adcr_pkg::*;
#(
  parameter int RST_HOLD_CYC = ADCR_RST_HOLD_CYC
)
(
  // Clock, reset and freeze
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  // User requests
  input  wire logic                   resetReq,
  input  wire adcr_mode_type          hostMode,
  // Captured results
  output logic [ADCR_WORD_W-1:0]      capWord,
  output logic                        capValid,
  output logic                        capOverrange,
  output logic                        flushing,
  // Link to converter
  adcr_link_if.cap                    link
);

  // Capture sequencer states
  typedef enum logic [2:0] {
    HS_HOLD  = 3'h1,
    HS_FLUSH = 3'h2,
    HS_RUN   = 3'h4
  } adcr_hst_type;

  localparam logic [ADCR_FLUSH_W-1:0] HOLD_LAST =
    ADCR_FLUSH_W'(RST_HOLD_CYC - 1);

  adcr_hst_type           state_q;
  adcr_hst_type           state_d;
  logic [ADCR_FLUSH_W-1:0] cnt_q;
  logic [ADCR_FLUSH_W-1:0] cnt_d;
  logic                   resetN_q;
  logic                   resetN_d;
  logic                   davPrev_q;
  logic                   davPrev_d;
  logic [ADCR_WORD_W-1:0] word_q;
  logic [ADCR_WORD_W-1:0] word_d;
  logic                   valid_q;
  logic                   valid_d;
  logic                   ovr_q;
  logic                   ovr_d;
  logic                   take;

  // Sequencer; a reset request restarts from any state
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q + 1'b1;
    case (state_q)
      HS_HOLD:
        if (cnt_q >= HOLD_LAST)
        begin
          state_d = HS_FLUSH;
          cnt_d   = '0;
        end
      HS_FLUSH:
        if (cnt_q >= flushLen(hostMode) - 1'b1)
        begin
          state_d = HS_RUN;
          cnt_d   = '0;
        end
      HS_RUN:
        cnt_d = '0;
      default:
      begin
        state_d = HS_HOLD;
        cnt_d   = '0;
      end
    endcase
    if (resetReq)
    begin
      // Several capture ends fed one request pulse in step
      state_d = HS_HOLD;
      cnt_d   = '0;
    end
    resetN_d = (state_d != HS_HOLD);
  end

  // Word taken on the strobe fall, long after it has settled; in 1x mode, whenever the strobe is high
  always_comb
  begin
    davPrev_d = link.dataValidStrobe;
    take      = (hostMode == ADCR_DEC1) ? link.dataValidStrobe
              : (davPrev_q && !link.dataValidStrobe);
    word_d    = take ? link.outputWordBits : word_q;
    // A take on the request edge is dropped, the word is stale by then
    valid_d   = take && (state_q == HS_RUN)
              && (state_d == HS_RUN);
    ovr_d     = link.overrangeFlag;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_q   <= HS_HOLD;
      cnt_q     <= '0;
      resetN_q  <= 1'b0;
      davPrev_q <= 1'b0;
      word_q    <= '0;
      valid_q   <= 1'b0;
      ovr_q     <= 1'b0;
    end
    else if (ce)
    begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      resetN_q  <= resetN_d;
      davPrev_q <= davPrev_d;
      word_q    <= word_d;
      valid_q   <= valid_d;
      ovr_q     <= ovr_d;
    end
  end

  assign link.resetN  = resetN_q;
  assign capWord      = word_q;
  assign capValid     = valid_q;
  assign capOverrange = ovr_q;
  assign flushing     = (state_q != HS_RUN);

endmodule

// [adcr_link_props.sv]
// Concurrent checks on the link between converter and capture ends
`timescale 1ns/1ps
module adcr_link_props
  import adcr_pkg::*;
#(
  parameter int RST_HOLD_CYC = ADCR_RST_HOLD_CYC
)
(
  // Clock and core reset
  input wire logic                         core_clk,
  input wire logic                         rst,
  // Modulator data seen by the converter
  input wire logic signed [ADCR_MOD_W-1:0] modSample,
  // Link signals
  input wire logic                         resetN,
  input wire logic                         dataValidStrobe,
  input wire logic [ADCR_WORD_W-1:0]       outputWordBits,
  input wire logic                         overrangeFlag
);
  logic [3:0] hiCnt_q;
  logic [3:0] hiCnt_d;
  logic [3:0] loCnt_q;
  logic [3:0] loCnt_d;
  logic [3:0] hiLen_q;
  logic [3:0] hiLen_d;
  logic [7:0] lowCnt_q;
  logic [7:0] lowCnt_d;

  // Strobe run lengths; a reset pulse forgets the last high run
  always_comb
  begin
    hiCnt_d  = dataValidStrobe ? hiCnt_q + 4'h1 : 4'h0;
    loCnt_d  = dataValidStrobe ? 4'h0 : loCnt_q + 4'h1;
    hiLen_d  = hiLen_q;
    if (!resetN)
      hiLen_d = 4'h0;
    else if (!dataValidStrobe && hiCnt_q != 4'h0)
      hiLen_d = hiCnt_q;
    lowCnt_d = resetN ? 8'h0 : lowCnt_q + {7'h0, lowCnt_q != 8'hff};
  end

  // Core reset counts as a long link reset, so no false hold error
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      hiCnt_q  <= 4'h0;
      loCnt_q  <= 4'h0;
      hiLen_q  <= 4'h0;
      lowCnt_q <= 8'hff;
    end
    else
    begin
      hiCnt_q  <= hiCnt_d;
      loCnt_q  <= loCnt_d;
      hiLen_q  <= hiLen_d;
      lowCnt_q <= lowCnt_d;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  property p_rstLow;
    !resetN |-> !dataValidStrobe;
  endproperty
  a_rstLow: assert property (p_rstLow)
    else $error("strobe high while link reset low");

  property p_davQuiet;
    $rose(resetN) |-> !dataValidStrobe ##1 !dataValidStrobe;
  endproperty
  a_davQuiet: assert property (p_davQuiet)
    else $error("strobe too early after link reset");

  property p_davResume;
    $rose(resetN) |-> ##[1:8] (dataValidStrobe || !resetN);
  endproperty
  a_davResume: assert property (p_davResume)
    else $error("strobe did not resume after link reset");

  property p_wordLow;
    $fell(dataValidStrobe) ##1 !dataValidStrobe |-> $stable(outputWordBits);
  endproperty
  a_wordLow: assert property (p_wordLow)
    else $error("word changed while strobe low");

  property p_wordHold;
    !resetN ##1 !resetN |-> $stable(outputWordBits);
  endproperty
  a_wordHold: assert property (p_wordHold)
    else $error("word changed during link reset");

  property p_duty;
    dataValidStrobe && loCnt_q != 4'h0 && hiLen_q != 4'h0
      |-> loCnt_q == hiLen_q;
  endproperty
  a_duty: assert property (p_duty)
    else $error("strobe high and low lengths differ");

  property p_rstHold;
    $rose(resetN) |-> lowCnt_q >= RST_HOLD_CYC;
  endproperty
  a_rstHold: assert property (p_rstHold)
    else $error("link reset pulse too short");

  property p_otrMod;
    (resetN && (modSample > ADCR_MOD_POS || modSample < ADCR_MOD_NEG))
      ##1 resetN [*3] |-> ##[0:3] overrangeFlag;
  endproperty
  a_otrMod: assert property (p_otrMod)
    else $error("modulator overrange not flagged in time");
endmodule

// [test_decimating_adc_reset_overrange_mode.sv]
// Self-checking bench: two converters and a capture end on one reset
`timescale 1ns/1ps
module test_decimating_adc_reset_overrange_mode;
  import adcr_pkg::*;

  localparam int HOLD = 8;
  localparam logic [2:0] CMP [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
  localparam int RAT [4] = '{8, 2, 4, 1};
  localparam int FLU [4] = '{321, 23, 108, 1};
  localparam adcr_mode_type HM [4] =
    '{ADCR_DEC8, ADCR_DEC2, ADCR_DEC4, ADCR_DEC1};

  logic                         core_clk;
  logic                         rst;
  logic                         ce;
  logic                         ce2;
  logic                         resetReq;
  logic                         randOn;
  logic                         chk8;
  logic                         prv;
  logic signed [ADCR_MOD_W-1:0] modSample;
  logic [2:0]                   modeCmp;
  adcr_mode_type                hostMode;
  logic [ADCR_WORD_W-1:0]       capWord;
  logic [ADCR_WORD_W-1:0]       hiW;
  logic                         capValid;
  logic                         capOverrange;
  logic                         flushing;
  int                           fails;
  int                           n_tests;
  int                           cycles;
  int                           seed;
  int                           k;
  int                           hi;
  int                           up;
  int                           r;

  adcr_link_if link ();
  adcr_link_if link2 ();
  // Second converter listens to the same reset line
  assign link2.resetN = link.resetN;

  adcr_device adcr_device_inst (.core_clk(core_clk), .rst(rst), .ce(ce),
    .modSample(modSample), .modeCmp(modeCmp), .link(link));
  adcr_device adcr_device_inst2 (.core_clk(core_clk), .rst(rst), .ce(ce2),
    .modSample(modSample), .modeCmp(modeCmp), .link(link2));
  adcr_capture #(.RST_HOLD_CYC(HOLD)) adcr_capture_inst (
    .core_clk(core_clk), .rst(rst), .ce(ce), .resetReq(resetReq),
    .hostMode(hostMode), .capWord(capWord), .capValid(capValid),
    .capOverrange(capOverrange), .flushing(flushing), .link(link));
  adcr_link_props #(.RST_HOLD_CYC(HOLD)) adcr_link_props_inst (
    .core_clk(core_clk), .rst(rst), .modSample(modSample),
    .resetN(link.resetN), .dataValidStrobe(link.dataValidStrobe),
    .outputWordBits(link.outputWordBits),
    .overrangeFlag(link.overrangeFlag));

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // All drives land 1 ns after the rising edge
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  // High samples of the strobe in a 64-cycle window
  function automatic int expHigh(input int d);
    return d == 1 ? 64 : 32;
  endfunction

  // Hang guard, well above the expected run length
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 6000)
    begin
      fails = fails + 1;
      finish_test();
    end
  end

  // Random in-range modulator data
  always @(posedge core_clk)
  begin
    if (randOn)
    begin
      #1 r = $random(seed);
      modSample <= {{3{r[15]}}, r[14:0]};
    end
  end

  // Capture monitor: no take while flushing, 8x takes match the link
  always @(posedge core_clk)
  begin
    #2;
    if (link.dataValidStrobe === 1'b1)
      hiW = link.outputWordBits;
    if (capValid === 1'b1 && flushing === 1'b1)
      check(32'h0, 32'h1);
    if (capValid === 1'b1 && chk8)
      check(capWord, hiW);
  end

  // Pulse a reset request and time the hold plus flush window
  task automatic pulse_reset(input int m);
    int w;
    w = 0;
    modeCmp  = CMP[m];
    hostMode = HM[m];
    resetReq = 1'b1;
    tick();
    resetReq = 1'b0;
    while (flushing !== 1'b0 && w < 600)
    begin
      tick();
      w = w + 1;
    end
    check(w, HOLD + FLU[m]);
  endtask

  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    ce2 = 1'b1;
    resetReq = 1'b0;
    randOn = 1'b1;
    chk8 = 1'b0;
    modSample = 18'sh0;
    modeCmp = 3'h0;
    hostMode = ADCR_DEC8;
    fails = 0;
    n_tests = 0;
    cycles = 0;
    seed = 32'h7ba4;
    repeat (16) @(posedge core_clk);
    #1 rst = 1'b0;
    // Every mode; second converter is knocked out of step first
    for (k = 0; k < 4; k++)
    begin
      ce2 = 1'b0;
      repeat (3) tick();
      ce2 = 1'b1;
      pulse_reset(k);
      chk8 = (RAT[k] == 8);
      repeat (16) tick();
      hi = 0;
      up = 0;
      prv = link.dataValidStrobe;
      repeat (64)
      begin
        tick();
        hi = hi + (link.dataValidStrobe === 1'b1);
        up = up + (link.dataValidStrobe === 1'b1 && prv === 1'b0);
        prv = link.dataValidStrobe;
        check({link2.dataValidStrobe, link2.outputWordBits},
          {link.dataValidStrobe, link.outputWordBits});
      end
      check(hi, expHigh(RAT[k]));
      check(up, RAT[k] == 1 ? 0 : 64 / RAT[k]);
    end
    // One modulator overrange sample; random drive stops first
    randOn = 1'b0;
    pulse_reset(0);
    chk8 = 1'b1;
    modSample = 18'sh0;
    repeat (16) tick();
    check(link.overrangeFlag, 1'b0);
    check(capOverrange, 1'b0);
    modSample = ADCR_MOD_POS + 18'sh1;
    tick();
    modSample = 18'sh0;
    up = 0;
    // One bit per cycle, so the flag's exact delay is checked
    repeat (6)
    begin
      tick();
      up = (up << 1) | (link.overrangeFlag === 1'b1);
    end
    check(up, 32'h1 << (6 - ADCR_MOD_OTR_CYC));
    repeat (16) tick();
    check(link.overrangeFlag, 1'b0);
    // Sustained overrange both ways: filtered data limited to full scale
    for (k = 0; k < 2; k++)
    begin
      modSample = k ? 18'sh20000 : 18'sh1ffff;
      repeat (64) tick();
      check(link.outputWordBits, k ? 16'h8000 : 16'h7fff);
      check(link.overrangeFlag, 1'b1);
      check(capOverrange, 1'b1);
    end
    finish_test();
  end
endmodule
